// File: pwm_clk_pkg.sv
// Package with offsets, field positions, reset values and counts for the PWM clock and mode select block.
`default_nettype none
package pwm_clk_pkg;
    // ----------------------------------------------------------------
    // Register byte offsets on the register bus
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CLOCK_SELECT = 8'h00;
    localparam logic [7:0] OFS_PRESCALE = 8'h04;
    localparam logic [7:0] OFS_CENTER_ALIGN = 8'h08;
    localparam logic [7:0] OFS_UNIT_CONTROL = 8'h0C;
    localparam logic [7:0] OFS_SCALE_A = 8'h10;
    localparam logic [7:0] OFS_SCALE_B = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;

    // ----------------------------------------------------------------
    // Field positions and implemented bits
    // ----------------------------------------------------------------
    localparam int CODE_A_LSB = 0;
    localparam int CODE_B_LSB = 4;
    localparam int JOIN_01_BIT = 4;
    localparam int JOIN_23_BIT = 5;
    localparam int JOIN_45_BIT = 6;
    localparam logic [7:0] CHANNEL_MASK = 8'h3F;
    localparam logic [7:0] PRESCALE_MASK = 8'h77;
    localparam logic [7:0] CONTROL_MASK = 8'h7C;

    // ----------------------------------------------------------------
    // Reset values and counts
    // ----------------------------------------------------------------
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [6:0] PRESCALE_COUNT_RESET = 7'h00;
    localparam logic [9:0] SCALE_FULL_COUNT = 10'h200;
    localparam logic [31:0] READ_ZERO = 32'h00000000;
endpackage
`default_nettype wire

// File: pwm_scale_divider.sv
// Scaled clock divider: one tick per twice the scale value of source ticks.
`timescale 1ns/1ps
`default_nettype none
module pwm_scale_divider
(
    input wire logic ref_clk_in, // Bus clock.
    input wire logic reset_in, // Synchronous reset, active high.
    input wire logic src_tick_in, // Tick of the prescaled clock.
    input wire logic [7:0] scale_value_in, // Scale register value.
    input wire logic reload_in, // Pulse: scale register was written.
    output logic tick_out // Pulse: scaled clock tick.
);
    typedef struct packed
    {
        logic [9:0] count;
        logic tick;
    } div_state_t;

    div_state_t s;
    div_state_t next_s;
    logic [9:0] reload_value;

    // A zero scale counts as full scale so the divider never stalls.
    assign reload_value = (scale_value_in == 8'h00) ? pwm_clk_pkg::SCALE_FULL_COUNT
                                                    : {1'b0, scale_value_in, 1'b0};

    always_comb
    begin
        next_s = s;
        next_s.tick = 1'b0;
        if (reload_in)
        begin
            next_s.count = reload_value;
        end
        else if (src_tick_in)
        begin
            if (s.count <= 10'h001)
            begin
                next_s.tick = 1'b1;
                next_s.count = reload_value;
            end
            else
            begin
                next_s.count = s.count - 10'h001;
            end
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
        begin
            s.count <= pwm_clk_pkg::SCALE_FULL_COUNT;
            s.tick <= 1'b0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign tick_out = s.tick;

    a_scale_zero_full: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (reload_in && scale_value_in == 8'h00) |=> (s.count == 10'h200))
        else $error("Zero scale did not load full count of 512.");
endmodule
`default_nettype wire

// File: pwm_clock_and_mode_select.sv
// PWM clock source selection, prescalers, alignment and pair joining behind an Avalon-MM slave.
//
// Contract
// - Channels 0,1,4,5 use clock A when select is 0, scaled A when 1.
// - Channels 2,3 use clock B when select is 0, scaled B when 1.
// - Clock B is bus clock divided by two to the code, three-bit code.
// - Clock A has its own three-bit code, same encoding as clock B.
// - Alignment bit one selects center aligned output for that channel.
// - Alignment bit zero selects left aligned output for that channel.
// - Three join bits each merge one adjacent channel pair into 16 bits.
// - In a joined pair the even channel holds the high byte.
// - All these registers read and write at any time.
// - Scaled clock divides by twice scale value; zero means 256.
// - Joined pair takes clock, alignment from odd channel; odd pin drives.
//
// Added by the designer: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pwm_clock_and_mode_select
(
    input wire logic ref_clk_in, // Bus clock, 100 MHz.
    input wire logic reset_in, // Synchronous reset, active high.
    input wire logic [7:0] address_in, // Avalon byte address.
    input wire logic read_in, // Avalon read request.
    input wire logic write_in, // Avalon write request.
    input wire logic [3:0] byteenable_in, // Avalon byte enables.
    input wire logic [31:0] writedata_in, // Avalon write data.
    output logic [31:0] readdata_out, // Avalon read data.
    output logic waitrequest_out, // Avalon wait request.
    output logic [5:0] ch_tick_out, // Per channel clock tick pulses.
    output logic [5:0] ch_center_out, // Per channel center aligned mode.
    output logic [5:0] pin_active_out, // Per channel pin carries output.
    output logic [2:0] joined_out, // Joined pairs 45, 23, 01 at bits 2..0.
    output logic [5:0] high_byte_out // Channel acts as high byte of a 16-bit pair.
);
    typedef struct packed
    {
        logic [7:0] clock_select;
        logic [7:0] prescale;
        logic [7:0] center_align;
        logic [7:0] unit_control;
        logic [7:0] scale_a;
        logic [7:0] scale_b;
        logic [6:0] prescale_count;
        logic tick_a;
        logic tick_b;
        logic waitrequest;
        logic [31:0] readdata;
        logic [5:0] ch_tick;
        logic [5:0] ch_center;
        logic [5:0] pin_active;
        logic [2:0] joined;
        logic [5:0] high_byte;
    } sel_state_t;

    sel_state_t s;
    sel_state_t next_s;
    logic scaled_clock_a;
    logic scaled_clock_b;
    logic scale_a_load;
    logic scale_b_load;
    logic do_write;
    logic write_ok;
    logic [7:0] scale_a_now;
    logic [7:0] scale_b_now;

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------
    // Low bits of the free running counter that must all be one for a tick.
    function automatic logic [6:0] div_mask(input logic [2:0] code);
        logic [7:0] one_hot;
        one_hot = 8'h01 << code;
        div_mask = 7'(one_hot - 8'h01);
    endfunction

    // Every input is an argument, so a continuous assignment that calls this follows each change.
    function automatic logic write_hit(input logic ok, input logic [7:0] addr, input logic [7:0] offset);
        write_hit = ok && (addr == offset);
    endfunction

    // ----------------------------------------------------------------
    // Scaled clock dividers
    // ----------------------------------------------------------------
    pwm_scale_divider scale_a_div
    (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .src_tick_in(s.tick_a),
        .scale_value_in(scale_a_now),
        .reload_in(scale_a_load),
        .tick_out(scaled_clock_a)
    );

    pwm_scale_divider scale_b_div
    (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .src_tick_in(s.tick_b),
        .scale_value_in(scale_b_now),
        .reload_in(scale_b_load),
        .tick_out(scaled_clock_b)
    );

    // A request is answered on the cycle after it is seen, with waitrequest low.
    assign do_write = write_in && !s.waitrequest;
    assign write_ok = do_write && byteenable_in[0];
    assign scale_a_load = write_hit(write_ok, address_in, pwm_clk_pkg::OFS_SCALE_A);
    assign scale_b_load = write_hit(write_ok, address_in, pwm_clk_pkg::OFS_SCALE_B);
    // The counter reloads at the write edge, so it must see the byte being written, not the old one.
    assign scale_a_now = scale_a_load ? writedata_in[7:0] : s.scale_a;
    assign scale_b_now = scale_b_load ? writedata_in[7:0] : s.scale_b;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        logic [2:0] code_a;
        logic [2:0] code_b;
        logic [5:0] eff_sel;
        logic [5:0] eff_center;
        logic [2:0] join_bits;
        code_a = s.prescale[pwm_clk_pkg::CODE_A_LSB +: 3];
        code_b = s.prescale[pwm_clk_pkg::CODE_B_LSB +: 3];
        join_bits = {s.unit_control[pwm_clk_pkg::JOIN_45_BIT], s.unit_control[pwm_clk_pkg::JOIN_23_BIT],
                s.unit_control[pwm_clk_pkg::JOIN_01_BIT]};
        eff_sel = s.clock_select[5:0];
        eff_center = s.center_align[5:0];
        next_s = s;

        // Register writes take effect at the edge that sees waitrequest low.
        if (write_hit(write_ok, address_in, pwm_clk_pkg::OFS_CLOCK_SELECT))
        begin
            next_s.clock_select = writedata_in[7:0] & pwm_clk_pkg::CHANNEL_MASK;
        end
        if (write_hit(write_ok, address_in, pwm_clk_pkg::OFS_PRESCALE))
        begin
            next_s.prescale = writedata_in[7:0] & pwm_clk_pkg::PRESCALE_MASK;
        end
        if (write_hit(write_ok, address_in, pwm_clk_pkg::OFS_CENTER_ALIGN))
        begin
            next_s.center_align = writedata_in[7:0] & pwm_clk_pkg::CHANNEL_MASK;
        end
        if (write_hit(write_ok, address_in, pwm_clk_pkg::OFS_UNIT_CONTROL))
        begin
            next_s.unit_control = writedata_in[7:0] & pwm_clk_pkg::CONTROL_MASK;
        end
        if (scale_a_load)
        begin
            next_s.scale_a = writedata_in[7:0];
        end
        if (scale_b_load)
        begin
            next_s.scale_b = writedata_in[7:0];
        end

        // Bus handshake: one wait cycle, then one answer cycle.
        next_s.waitrequest = !((read_in || write_in) && s.waitrequest);
        next_s.readdata = pwm_clk_pkg::READ_ZERO;
        if (read_in && s.waitrequest)
        begin
            unique case (address_in)
                pwm_clk_pkg::OFS_CLOCK_SELECT: next_s.readdata[7:0] = s.clock_select;
                pwm_clk_pkg::OFS_PRESCALE: next_s.readdata[7:0] = s.prescale;
                pwm_clk_pkg::OFS_CENTER_ALIGN: next_s.readdata[7:0] = s.center_align;
                pwm_clk_pkg::OFS_UNIT_CONTROL: next_s.readdata[7:0] = s.unit_control;
                pwm_clk_pkg::OFS_SCALE_A: next_s.readdata[7:0] = s.scale_a;
                pwm_clk_pkg::OFS_SCALE_B: next_s.readdata[7:0] = s.scale_b;
                pwm_clk_pkg::OFS_STATUS: next_s.readdata[10:0] = {s.joined, 1'b0, s.prescale_count};
                default: next_s.readdata = pwm_clk_pkg::READ_ZERO;
            endcase
        end

        // Prescalers share one free running counter, so clocks A and B stay phase related.
        next_s.prescale_count = 7'(s.prescale_count + 7'h01);
        next_s.tick_a = (s.prescale_count & div_mask(code_a)) == div_mask(code_a);
        next_s.tick_b = (s.prescale_count & div_mask(code_b)) == div_mask(code_b);

        // A joined pair runs on the odd channel's clock choice and alignment.
        for (int p = 0; p < 3; p++)
        begin
            if (join_bits[p])
            begin
                eff_sel[2 * p] = s.clock_select[2 * p + 1];
                eff_center[2 * p] = s.center_align[2 * p + 1];
            end
            next_s.pin_active[2 * p] = !join_bits[p];
            next_s.pin_active[2 * p + 1] = 1'b1;
            next_s.high_byte[2 * p] = join_bits[p];
            next_s.high_byte[2 * p + 1] = 1'b0;
        end
        for (int c = 0; c < 6; c++)
        begin
            if (c == 2 || c == 3)
            begin
                next_s.ch_tick[c] = eff_sel[c] ? scaled_clock_b : s.tick_b;
            end
            else
            begin
                next_s.ch_tick[c] = eff_sel[c] ? scaled_clock_a : s.tick_a;
            end
        end
        next_s.ch_center = eff_center;
        next_s.joined = join_bits;
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
        begin
            s.clock_select <= pwm_clk_pkg::RESET_BYTE;
            s.prescale <= pwm_clk_pkg::RESET_BYTE;
            s.center_align <= pwm_clk_pkg::RESET_BYTE;
            s.unit_control <= pwm_clk_pkg::RESET_BYTE;
            s.scale_a <= pwm_clk_pkg::RESET_BYTE;
            s.scale_b <= pwm_clk_pkg::RESET_BYTE;
            s.prescale_count <= pwm_clk_pkg::PRESCALE_COUNT_RESET;
            s.tick_a <= 1'b0;
            s.tick_b <= 1'b0;
            s.waitrequest <= 1'b1;
            s.readdata <= pwm_clk_pkg::READ_ZERO;
            s.ch_tick <= 6'h00;
            s.ch_center <= 6'h00;
            s.pin_active <= 6'h3F;
            s.joined <= 3'h0;
            s.high_byte <= 6'h00;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign readdata_out = s.readdata;
    assign waitrequest_out = s.waitrequest;
    assign ch_tick_out = s.ch_tick;
    assign ch_center_out = s.ch_center;
    assign pin_active_out = s.pin_active;
    assign joined_out = s.joined;
    assign high_byte_out = s.high_byte;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_reset_all_zero: assert property (@(posedge ref_clk_in)
        $past(reset_in) |-> (s.clock_select == 8'h00 && s.prescale == 8'h00 && s.center_align == 8'h00
                             && s.unit_control == 8'h00))
        else $error("Select, prescale, alignment or join bits not zero after reset.");

    a_write_any_time: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (do_write && address_in == 8'h08 && byteenable_in[0]) |=>
            (s.center_align == ($past(writedata_in[7:0]) & 8'h3F)))
        else $error("Alignment register write did not take effect.");

    a_wait_one_cycle: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        ($rose(read_in || write_in) && waitrequest_out) |=> !waitrequest_out ##1 waitrequest_out)
        else $error("Bus answer not given exactly one cycle after request.");

    a_idle_data_zero: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        waitrequest_out |-> (readdata_out == 32'h00000000))
        else $error("Read data not zero outside an answer cycle.");

    a_answer_one_cycle: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        !waitrequest_out |=> waitrequest_out)
        else $error("Wait request stayed low for more than one cycle.");

    // The first cycle after reset still shows the cleared tick, so reset must have been low twice.
    a_clock_a_undivided: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (!reset_in && s.prescale[2:0] == 3'h0)[*2] |-> s.tick_a)
        else $error("Clock A with code 0 is not the bus clock.");

    a_clock_a_div2: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (s.prescale[2:0] == 3'h1)[*3] |-> (s.tick_a != $past(s.tick_a)))
        else $error("Clock A with code 1 does not tick every other cycle.");

    a_clock_b_undivided: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (!reset_in && s.prescale[6:4] == 3'h0)[*2] |-> s.tick_b)
        else $error("Clock B with code 0 is not the bus clock.");

    a_clock_b_div8: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (s.tick_b && s.prescale[6:4] == 3'h3) ##1 (s.prescale[6:4] == 3'h3)[*8] |->
            $past(s.tick_b, 8) && !$past(s.tick_b, 7) && !$past(s.tick_b, 1))
        else $error("Clock B with code 3 does not tick every 8 cycles.");

    a_scaled_a_spacing: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        scaled_clock_a |=> !scaled_clock_a)
        else $error("Scaled clock A ticked in two cycles in a row.");

    a_ch0_source: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        ($past(s.unit_control[4]) == 1'b0) |->
            (ch_tick_out[0] == ($past(s.clock_select[0]) ? $past(scaled_clock_a) : $past(s.tick_a))))
        else $error("Channel 0 tick is not from the selected A clock.");

    a_ch4_source: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        !$past(s.unit_control[6]) |->
            (ch_tick_out[4] == ($past(s.clock_select[4]) ? $past(scaled_clock_a) : $past(s.tick_a))))
        else $error("Channel 4 tick is not from the selected A clock.");

    a_ch3_source: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        ch_tick_out[3] == ($past(s.clock_select[3]) ? $past(scaled_clock_b) : $past(s.tick_b)))
        else $error("Channel 3 tick is not from the selected B clock.");

    a_center_follows: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        !$past(s.unit_control[6]) |-> (ch_center_out[4] == $past(s.center_align[4])))
        else $error("Channel 4 alignment mode does not follow its bit.");

    a_ch1_center: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        ch_center_out[1] == $past(s.center_align[1]))
        else $error("Channel 1 alignment mode does not follow its bit.");

    a_join_bits_follow: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        joined_out == {$past(s.unit_control[6]), $past(s.unit_control[5]), $past(s.unit_control[4])})
        else $error("Joined pair flags do not follow the join bits.");

    a_split_pins: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (joined_out == 3'h0) |-> (pin_active_out == 6'h3F && high_byte_out == 6'h00))
        else $error("Separate channels do not all drive their own pins.");

    a_join_pair_01: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        joined_out[0] |-> (ch_tick_out[0] == ch_tick_out[1] && ch_center_out[0] == ch_center_out[1]
                           && !pin_active_out[0] && pin_active_out[1] && high_byte_out[0]))
        else $error("Joined pair 0/1 does not follow channel 1.");

    a_join_odd_rules: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        joined_out[1] |-> (ch_tick_out[2] == ch_tick_out[3] && ch_center_out[2] == ch_center_out[3]
                           && !pin_active_out[2] && pin_active_out[3] && high_byte_out[2]))
        else $error("Joined pair 2/3 does not follow channel 3.");

    a_join_pair_45: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        joined_out[2] |-> (ch_tick_out[4] == ch_tick_out[5] && ch_center_out[4] == ch_center_out[5]
                           && !pin_active_out[4] && pin_active_out[5] && high_byte_out[4]))
        else $error("Joined pair 4/5 does not follow channel 5.");
endmodule
`default_nettype wire

// File: tb.sv
// Self-checking testbench for the PWM clock and mode select block.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic ref_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [7:0] address_in = 8'h00;
    logic read_in = 1'b0;
    logic write_in = 1'b0;
    logic [3:0] byteenable_in = 4'hF;
    logic [31:0] writedata_in = 32'h00000000;
    logic [31:0] readdata_out;
    logic waitrequest_out;
    logic [5:0] ch_tick_out;
    logic [5:0] ch_center_out;
    logic [5:0] pin_active_out;
    logic [5:0] high_byte_out;
    logic [2:0] joined_out;
    logic [31:0] scratch;
    int err_total = 0;
    int total_checks = 0;
    int cycles = 0;
    // Longest test is the 512-cycle scaled period measured three times over; the rest is far shorter.
    localparam int CYCLE_LIMIT = 60000;
    localparam logic [7:0] OFS [6] = '{pwm_clk_pkg::OFS_CLOCK_SELECT, pwm_clk_pkg::OFS_PRESCALE,
        pwm_clk_pkg::OFS_CENTER_ALIGN, pwm_clk_pkg::OFS_UNIT_CONTROL, pwm_clk_pkg::OFS_SCALE_A,
        pwm_clk_pkg::OFS_SCALE_B};
    localparam logic [31:0] MASKS [6] = '{32'h3F, 32'h77, 32'h3F, 32'h7C, 32'hFF, 32'hFF};
    localparam int SCALED_PERIOD [6] = '{6, 6, 8, 8, 6, 6};
    localparam int PLAIN_PERIOD [6] = '{1, 1, 2, 2, 1, 1};

    pwm_clock_and_mode_select i_dut
    (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .address_in(address_in),
        .read_in(read_in),
        .write_in(write_in),
        .byteenable_in(byteenable_in),
        .writedata_in(writedata_in),
        .readdata_out(readdata_out),
        .waitrequest_out(waitrequest_out),
        .ch_tick_out(ch_tick_out),
        .ch_center_out(ch_center_out),
        .pin_active_out(pin_active_out),
        .joined_out(joined_out),
        .high_byte_out(high_byte_out)
    );

    initial
    begin
        forever #5 ref_clk_in = ~ref_clk_in;
    end

    // ----------------------------------------------------------------
    // Reporting
    // ----------------------------------------------------------------
    task automatic summarize();
        $display("Checks made %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    always @(posedge ref_clk_in)
    begin
        cycles <= cycles + 1;
        if (cycles == CYCLE_LIMIT)
        begin
            err_total++;
            $display("MISMATCH run time expected below %0d cycles seen %0d", CYCLE_LIMIT, cycles);
            summarize();
        end
    end

    // ----------------------------------------------------------------
    // Register bus access
    // ----------------------------------------------------------------
    // The request is held until the edge that samples waitrequest low; data is taken at that edge.
    task automatic bus_access(input logic wr, input logic [7:0] addr, input logic [31:0] data,
        input logic [3:0] be, output logic [31:0] rdata);
        int n;
        n = 0;
        @(posedge ref_clk_in);
        address_in <= addr;
        writedata_in <= data;
        byteenable_in <= be;
        write_in <= wr;
        read_in <= ~wr;
        do
        begin
            @(posedge ref_clk_in);
            n++;
        end
        while (waitrequest_out !== 1'b0 && n < 100);
        rdata = readdata_out;
        write_in <= 1'b0;
        read_in <= 1'b0;
        if (n >= 100)
            check("bus answer", 32'h00000000, 32'h00000001);
    endtask

    task automatic wr_reg(input logic [7:0] addr, input logic [31:0] data);
        logic [31:0] unused;
        bus_access(1'b1, addr, data, 4'hF, unused);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] addr, input logic [31:0] exp,
        input logic [31:0] mask);
        logic [31:0] rdata;
        bus_access(1'b0, addr, 32'h00000000, 4'hF, rdata);
        check(what, exp, rdata & mask);
    endtask

    // Outputs are registered and follow a write within two cycles.
    task automatic outputs_chk(input logic [5:0] center, input logic [2:0] joined, input logic [5:0] high,
        input logic [5:0] pins);
        repeat (3) @(negedge ref_clk_in);
        check("center", {26'h0, center}, {26'h0, ch_center_out});
        check("joined", {29'h0, joined}, {29'h0, joined_out});
        check("high byte", {26'h0, high}, {26'h0, high_byte_out});
        check("pin active", {26'h0, pins}, {26'h0, pin_active_out});
    endtask

    // ----------------------------------------------------------------
    // Tick period measurement
    // ----------------------------------------------------------------
    task automatic wait_tick(input int ch, output int n);
        n = 0;
        do
        begin
            @(negedge ref_clk_in);
            n++;
        end
        while (ch_tick_out[ch] !== 1'b1 && n < 2000);
    endtask

    // Two ticks are skipped first, since a change of source may cut or stretch one pulse.
    task automatic period(input int ch, input int exp);
        int n;
        wait_tick(ch, n);
        wait_tick(ch, n);
        wait_tick(ch, n);
        check($sformatf("tick period ch%0d", ch), exp, n);
    endtask

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial
    begin
        int lat;
        repeat (3) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        outputs_chk(6'h00, 3'h0, 6'h00, 6'h3F);
        for (int i = 0; i < 6; i++)
            rd_chk("reset value", OFS[i], 32'h00000000, 32'hFFFFFFFF);
        for (int i = 0; i < 6; i++)
        begin
            wr_reg(OFS[i], 32'hFFFFFFFF);
            rd_chk("read back", OFS[i], MASKS[i], 32'hFFFFFFFF);
        end
        bus_access(1'b1, pwm_clk_pkg::OFS_CLOCK_SELECT, 32'h00000000, 4'hE, scratch);
        rd_chk("byte lane off", pwm_clk_pkg::OFS_CLOCK_SELECT, 32'h3F, 32'hFFFFFFFF);
        wr_reg(8'h20, 32'hFF);
        rd_chk("unmapped", 8'h20, 32'h00000000, 32'hFFFFFFFF);
        for (int i = 0; i < 6; i++)
            wr_reg(OFS[i], 32'h00000000);
        wr_reg(pwm_clk_pkg::OFS_STATUS, 32'hFFFFFFFF);
        rd_chk("status joined", pwm_clk_pkg::OFS_STATUS, 32'h00000000, 32'h700);
        // No channel is ever enabled here, so alignment and join bits may be changed freely.
        wr_reg(pwm_clk_pkg::OFS_CENTER_ALIGN, 32'h15);
        outputs_chk(6'h15, 3'h0, 6'h00, 6'h3F);
        wr_reg(pwm_clk_pkg::OFS_CENTER_ALIGN, 32'h2A);
        outputs_chk(6'h2A, 3'h0, 6'h00, 6'h3F);
        for (int n = 0; n < 8; n++)
        begin
            wr_reg(pwm_clk_pkg::OFS_PRESCALE, {24'h0, 1'b0, 3'(7 - n), 1'b0, 3'(n)});
            period(0, 1 << n);
            period(2, 1 << (7 - n));
        end
        wr_reg(pwm_clk_pkg::OFS_PRESCALE, 32'h10);
        wr_reg(pwm_clk_pkg::OFS_SCALE_A, 32'h03);
        wr_reg(pwm_clk_pkg::OFS_SCALE_B, 32'h02);
        wr_reg(pwm_clk_pkg::OFS_CLOCK_SELECT, 32'h3F);
        for (int c = 0; c < 6; c++)
            period(c, SCALED_PERIOD[c]);
        wr_reg(pwm_clk_pkg::OFS_CLOCK_SELECT, 32'h00);
        for (int c = 0; c < 6; c++)
            period(c, PLAIN_PERIOD[c]);
        wr_reg(pwm_clk_pkg::OFS_SCALE_A, 32'h00);
        wr_reg(pwm_clk_pkg::OFS_CLOCK_SELECT, 32'h01);
        period(0, 512);
        wr_reg(pwm_clk_pkg::OFS_UNIT_CONTROL, 32'h70);
        outputs_chk(6'h3F, 3'h7, 6'h15, 6'h2A);
        rd_chk("status joined", pwm_clk_pkg::OFS_STATUS, 32'h700, 32'h700);
        wr_reg(pwm_clk_pkg::OFS_UNIT_CONTROL, 32'h10);
        wr_reg(pwm_clk_pkg::OFS_CLOCK_SELECT, 32'h02);
        // The old full-scale count would hold the first tick back by some 512 cycles.
        wr_reg(pwm_clk_pkg::OFS_SCALE_A, 32'h03);
        wait_tick(0, lat);
        check("scale reload latency", 32'h00000001, {31'h0, lat <= 12});
        outputs_chk(6'h2B, 3'h1, 6'h01, 6'h3E);
        period(0, 6);
        summarize();
    end
endmodule
`default_nettype wire
